/* File: src/codec_regs.sv */
// What this block does
// - bits 7..4 of gain flags report headphone and line driver gain settled, reset 0.
// - bits 3..0 report bypass and mixer amp volume settled, read-only, reset 0.
// - reserved registers and fields read zero; host writes only zeros there.
// - six-bit input power-up code, reset 0; 31h 3.1ms, 32h 6.4ms, 33h 1.6ms.
// - reference codes 000..011: slow, 40, 80, 120 ms with analog blocks.
// - reference codes with top bit force power-up; 101..111 give 40, 80, 120 ms.
// - register 0 of every page is read/write page select, reset zero.
// - config bit 2 enables adaptive filtering for the ADC, reset 0.
// - read-only bit 1 shows which bank filter and host each use in adaptive mode; otherwise both use bank A.
// - writing 1 to bit 0 asks for bank swap at next frame, adaptive only.
// - the swap request bit clears itself once the swap is done.
// - coefficient page registers 8..127 hold bank bytes, contents undefined at reset.
// - with adaptive off, coefficient access only while ADC is powered down.
`timescale 1ns/100ps
`default_nettype none
`include "codec_regs_defs.svh"

module powerup_timer #(
    parameter int W = 24
) (
    input  wire logic         clock_i,
    input  wire logic         nrst_i,
    input  wire logic         run_i,
    input  wire logic [W-1:0] cycles_i,
    output logic              ready_o
);
    codec_regs_pkg::pwr_state_e state_reg;
    codec_regs_pkg::pwr_state_e state_next;
    logic [W-1:0]               count_reg;
    logic                       ready_reg;

    wire logic expired = (count_reg + W'(1)) >= cycles_i;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            codec_regs_pkg::PWR_IDLE: begin
                if (run_i) begin
                    state_next = codec_regs_pkg::PWR_RAMP;
                end
            end
            codec_regs_pkg::PWR_RAMP: begin
                if (!run_i) begin
                    state_next = codec_regs_pkg::PWR_IDLE;
                end else if (expired) begin
                    state_next = codec_regs_pkg::PWR_DONE;
                end
            end
            codec_regs_pkg::PWR_DONE: begin
                if (!run_i) begin
                    state_next = codec_regs_pkg::PWR_IDLE;
                end
            end
            default: begin
                state_next = codec_regs_pkg::PWR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= codec_regs_pkg::PWR_IDLE;
            count_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= (state_reg == codec_regs_pkg::PWR_RAMP) ? count_reg + W'(1) : '0;
            ready_reg <= (state_next == codec_regs_pkg::PWR_DONE);
        end
    end

    assign ready_o = ready_reg;
endmodule // powerup_timer

module codec_regs #(
    parameter int unsigned REF_40_CYC   = `REF_T_40_MS * 1000 * `CYC_PER_US,
    // the 80 and 120 ms reference times are whole multiples of the 40 ms one
    parameter int unsigned REF_80_CYC   = REF_40_CYC * (`REF_T_80_MS / `REF_T_40_MS),
    parameter int unsigned REF_120_CYC  = REF_40_CYC * (`REF_T_120_MS / `REF_T_40_MS),
    parameter int unsigned REF_SLOW_CYC = `REF_T_SLOW_MS * 1000 * `CYC_PER_US,
    parameter int unsigned IN_1P6_CYC   = `QCHG_T_1P6_US * `CYC_PER_US,
    parameter int unsigned IN_3P1_CYC   = `QCHG_T_3P1_US * `CYC_PER_US,
    parameter int unsigned IN_6P4_CYC   = `QCHG_T_6P4_US * `CYC_PER_US
) (
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic [6:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic [7:0] gain_settled_i,
    input  wire logic       analog_on_i,
    input  wire logic       adc_on_i,
    input  wire logic       adc_frame_i,
    input  wire logic [6:0] filt_addr_i,
    output logic      [7:0] filt_data_o,
    output logic            adaptive_en_o,
    output logic            filter_bank_o,
    output logic            ref_force_o,
    output logic            ref_ready_o,
    output logic            inputs_ready_o,
    output logic            irq_o
);
    localparam int TW = `TIMER_W;

    // pin synchronisers: {frame, adc_on, analog_on, gain flags}
    logic [10:0] sync1_reg;
    logic [10:0] sync2_reg;
    logic        frame_d_reg;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_reg   <= 11'h000;
            sync2_reg   <= 11'h000;
            frame_d_reg <= 1'b0;
        end else begin
            sync1_reg   <= {adc_frame_i, adc_on_i, analog_on_i, gain_settled_i};
            sync2_reg   <= sync1_reg;
            frame_d_reg <= sync2_reg[10];
        end
    end

    wire logic [7:0] gain_s      = sync2_reg[7:0];
    wire logic       analog_on_s = sync2_reg[8];
    wire logic       adc_on_s    = sync2_reg[9];
    wire logic       frame_edge  = sync2_reg[10] & ~frame_d_reg;

    // control state
    codec_regs_pkg::reg_byte_t page_reg;
    logic [5:0]                qchg_reg;
    logic [2:0]                refpu_reg;
    logic                      adapt_en_reg;
    logic                      bank_reg;
    logic                      swap_req_reg;
    logic [`EV_COUNT-1:0]      status_reg;
    logic [`EV_COUNT-1:0]      enable_reg;
    logic                      irq_reg;
    codec_regs_pkg::reg_byte_t rdata_reg;
    codec_regs_pkg::reg_byte_t filt_data_reg;
    codec_regs_pkg::reg_byte_t coef_mem [0:1][0:`COEF_BYTES-1];

    // address decode
    wire logic on_flag_page = page_reg == `FLAG_PAGE;
    wire logic on_coef_page = page_reg == `COEF_PAGE;
    wire logic on_irq_page  = page_reg == `IRQ_PAGE;
    wire logic sel_page     = addr_i == `PAGE_SEL_OFS;
    wire logic sel_gain     = on_flag_page && addr_i == `GAIN_FLAGS_OFS;
    wire logic sel_qchg     = on_flag_page && addr_i == `QCHG_OFS;
    wire logic sel_refpu    = on_flag_page && addr_i == `REFPU_OFS;
    wire logic sel_rsvd1    = on_flag_page && addr_i >= `RSVD_A_FIRST_OFS
                              && !sel_qchg && !sel_refpu;
    wire logic sel_cfg      = on_coef_page && addr_i == `ADAPT_CFG_OFS;
    wire logic sel_rsvd8    = on_coef_page && addr_i > `ADAPT_CFG_OFS
                              && addr_i < `COEF_FIRST_OFS;
    wire logic sel_coef     = on_coef_page && addr_i >= `COEF_FIRST_OFS;
    wire logic sel_status   = on_irq_page && addr_i == `IRQ_STATUS_OFS;
    wire logic sel_clear    = on_irq_page && addr_i == `IRQ_CLEAR_OFS;
    wire logic sel_enable   = on_irq_page && addr_i == `IRQ_ENABLE_OFS;

    wire logic [6:0] coef_idx = addr_i - `COEF_FIRST_OFS;

    // filter and host always sit on opposite banks in adaptive mode; bank A otherwise
    wire logic filt_bank = adapt_en_reg ? bank_reg : 1'b0;
    wire logic host_bank = adapt_en_reg ? ~bank_reg : 1'b0;

    // coefficients may be touched freely in adaptive mode, else only with the ADC off
    wire logic coef_allowed = adapt_en_reg || !adc_on_s;
    wire logic coef_wr      = wr_i && sel_coef && coef_allowed;

    wire logic do_swap = swap_req_reg && adapt_en_reg && frame_edge;

    wire logic qchg_valid = qchg_reg == `QCHG_CODE_3P1 || qchg_reg == `QCHG_CODE_6P4
                            || qchg_reg == `QCHG_CODE_1P6;
    wire logic qchg_wr_bad = wr_i && sel_qchg && wdata_i[5:0] != `QCHG_CODE_3P1
                             && wdata_i[5:0] != `QCHG_CODE_6P4
                             && wdata_i[5:0] != `QCHG_CODE_1P6;

    // nonzero write into a reserved register or field
    wire logic rsvd_wr = wr_i && (((sel_rsvd1 || sel_rsvd8) && wdata_i != 8'h00)
                         || (sel_qchg && wdata_i[7:6] != 2'h0)
                         || ((sel_refpu || sel_cfg) && wdata_i[7:3] != 5'h00));

    wire logic [`EV_COUNT-1:0] events;
    assign events[`EV_SWAP]     = do_swap;
    assign events[`EV_REFUSED]  = (wr_i || rd_i) && sel_coef && !coef_allowed;
    assign events[`EV_BAD_QCHG] = qchg_wr_bad;
    assign events[`EV_RSVD_WR]  = rsvd_wr;

    wire logic [`EV_COUNT-1:0] clear_mask = (wr_i && sel_clear) ? wdata_i[`EV_COUNT-1:0]
                                                                : '0;
    // a new event wins over a clear in the same cycle
    wire logic [`EV_COUNT-1:0] status_next = (status_reg & ~clear_mask) | events;

    // a write of 1 in the swap cycle leaves a fresh request standing
    wire logic swap_req_next = (wr_i && sel_cfg) ? wdata_i[`SWAP_REQ_BIT]
                               : (do_swap ? 1'b0 : swap_req_reg);

    // read mux; reserved and unmapped addresses read zero
    wire codec_regs_pkg::reg_byte_t rd_mux =
        sel_page                 ? page_reg :
        sel_gain                 ? gain_s :
        sel_qchg                 ? {2'h0, qchg_reg} :
        sel_refpu                ? {5'h00, refpu_reg} :
        sel_cfg                  ? {5'h00, adapt_en_reg, bank_reg, swap_req_reg} :
        sel_coef && coef_allowed ? coef_mem[host_bank][coef_idx] :
        sel_status               ? {4'h0, status_reg} :
        sel_enable               ? {4'h0, enable_reg} :
                                   8'h00;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            page_reg     <= `PAGE_RST;
            qchg_reg     <= `QCHG_RST;
            refpu_reg    <= `REFPU_RST;
            adapt_en_reg <= `ADAPT_EN_RST;
            bank_reg     <= `BANK_FLAG_RST;
            swap_req_reg <= `SWAP_REQ_RST;
            status_reg   <= `IRQ_RST;
            enable_reg   <= `IRQ_RST;
            irq_reg      <= 1'b0;
            rdata_reg    <= 8'h00;
        end else begin
            if (wr_i && sel_page) begin
                page_reg <= wdata_i;
            end
            if (wr_i && sel_qchg) begin
                qchg_reg <= wdata_i[5:0];
            end
            if (wr_i && sel_refpu) begin
                refpu_reg <= wdata_i[2:0];
            end
            if (wr_i && sel_cfg) begin
                adapt_en_reg <= wdata_i[`ADAPT_EN_BIT];
            end
            if (wr_i && sel_enable) begin
                enable_reg <= wdata_i[`EV_COUNT-1:0];
            end
            if (do_swap) begin
                bank_reg <= ~bank_reg;
            end
            swap_req_reg <= swap_req_next;
            status_reg   <= status_next;
            irq_reg      <= |(status_reg & enable_reg);
            rdata_reg    <= rd_i ? rd_mux : 8'h00;
        end
    end

    // coefficient storage has no reset; contents start undefined
    always_ff @(posedge clock_i) begin
        if (coef_wr) begin
            coef_mem[host_bank][coef_idx] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            filt_data_reg <= 8'h00;
        end else if (filt_addr_i < 7'(`COEF_BYTES)) begin
            filt_data_reg <= coef_mem[filt_bank][filt_addr_i];
        end else begin
            filt_data_reg <= 8'h00;
        end
    end

    // reference power-up: forced codes run regardless of analog blocks
    wire logic ref_run = refpu_reg[`REF_FORCE_BIT] || analog_on_s;
    wire logic [TW-1:0] ref_cycles =
        (refpu_reg[1:0] == 2'h1) ? TW'(REF_40_CYC) :
        (refpu_reg[1:0] == 2'h2) ? TW'(REF_80_CYC) :
        (refpu_reg[1:0] == 2'h3) ? TW'(REF_120_CYC) :
                                   TW'(REF_SLOW_CYC);

    // analog inputs do not ramp while the power-up code is still the default or prohibited
    wire logic in_run = analog_on_s && qchg_valid;
    wire logic [TW-1:0] in_cycles =
        (qchg_reg == `QCHG_CODE_3P1) ? TW'(IN_3P1_CYC) :
        (qchg_reg == `QCHG_CODE_6P4) ? TW'(IN_6P4_CYC) :
                                       TW'(IN_1P6_CYC);

    powerup_timer #(
        .W (TW)
    ) u_ref_timer (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .run_i    (ref_run),
        .cycles_i (ref_cycles),
        .ready_o  (ref_ready_o)
    );

    powerup_timer #(
        .W (TW)
    ) u_in_timer (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .run_i    (in_run),
        .cycles_i (in_cycles),
        .ready_o  (inputs_ready_o)
    );

    assign rdata_o       = rdata_reg;
    assign filt_data_o   = filt_data_reg;
    assign adaptive_en_o = adapt_en_reg;
    assign filter_bank_o = bank_reg;
    assign ref_force_o   = refpu_reg[`REF_FORCE_BIT];
    assign irq_o         = irq_reg;

    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_swap_event;
        swap_req_reg && adapt_en_reg && frame_edge;
    endsequence

    sequence s_no_rearm;
        !(wr_i && sel_cfg && wdata_i[`SWAP_REQ_BIT]);
    endsequence

    sequence s_gain_read;
        rd_i && sel_gain;
    endsequence

    a_swap_toggles_bank: assert property (
        s_swap_event |=> bank_reg != $past(bank_reg))
        else $error("bank flag did not toggle on swap");

    a_swap_self_clear: assert property (
        s_swap_event ##0 s_no_rearm |=> !swap_req_reg)
        else $error("swap request did not clear after swap");

    a_bank_only_swap: assert property (
        $changed(bank_reg) |-> $past(swap_req_reg && adapt_en_reg && frame_edge))
        else $error("bank flag changed without a swap");

    a_no_swap_disabled: assert property (
        !adapt_en_reg |=> $stable(bank_reg))
        else $error("bank swapped with adaptive filtering off");

    a_gain_flags_read: assert property (
        s_gain_read |=> rdata_o[7:4] == $past(gain_settled_i[7:4], 3))
        else $error("driver gain flags read wrong");

    a_volume_flags_read: assert property (
        s_gain_read |=> rdata_o[3:0] == $past(gain_settled_i[3:0], 3))
        else $error("bypass or mixer volume flags read wrong");

    a_reserved_read_zero: assert property (
        rd_i && (sel_rsvd1 || sel_rsvd8) |=> rdata_o == 8'h00)
        else $error("reserved register read nonzero");

    a_page_select_write: assert property (
        wr_i && sel_page ##1 rd_i && addr_i == `PAGE_SEL_OFS |=> rdata_o == $past(wdata_i, 2))
        else $error("page select did not read back");

    a_adaptive_enable: assert property (
        wr_i && sel_cfg |=> adaptive_en_o == $past(wdata_i[`ADAPT_EN_BIT]))
        else $error("adaptive enable not taken");

    a_banks_apart: assert property (
        adapt_en_reg |-> host_bank != filt_bank && filt_bank == bank_reg)
        else $error("host and filter share a bank in adaptive mode");

    a_refused_access: assert property (
        rd_i && sel_coef && !adapt_en_reg && adc_on_s |=> rdata_o == 8'h00
            && status_reg[`EV_REFUSED])
        else $error("coefficient access not refused while ADC runs");

    a_ref_force_runs: assert property (
        ref_force_o |-> ref_run)
        else $error("forced reference not running");

    a_ref_idle_off: assert property (
        !ref_run |=> !ref_ready_o)
        else $error("reference ready without power-up");

    a_inputs_need_code: assert property (
        !qchg_valid |=> !inputs_ready_o)
        else $error("inputs ready with default or prohibited code");

endmodule // codec_regs
`default_nettype wire

/* File: src/codec_regs_defs.svh */
`ifndef CODEC_REGS_DEFS_SVH
`define CODEC_REGS_DEFS_SVH

// clock
`define CLK_HZ              50000000
`define CYC_PER_US          (`CLK_HZ / 1000000)

// register offsets within a page
`define PAGE_SEL_OFS        7'h00
`define GAIN_FLAGS_OFS      7'h3f
`define RSVD_A_FIRST_OFS    7'h40
`define QCHG_OFS            7'h47
`define RSVD_B_FIRST_OFS    7'h48
`define REFPU_OFS           7'h7b
`define RSVD_C_FIRST_OFS    7'h7c
`define ADAPT_CFG_OFS       7'h01
`define COEF_FIRST_OFS      7'h08
`define IRQ_STATUS_OFS      7'h01
`define IRQ_CLEAR_OFS       7'h02
`define IRQ_ENABLE_OFS      7'h03

// pages
`define FLAG_PAGE           8'h01
`define COEF_PAGE           8'h08
`define IRQ_PAGE            8'hfa

// sizes
`define COEF_BYTES          120
`define TIMER_W             24

// field positions
`define ADAPT_EN_BIT        2
`define BANK_FLAG_BIT       1
`define SWAP_REQ_BIT        0
`define REF_FORCE_BIT       2

// reset values
`define PAGE_RST            8'h00
`define QCHG_RST            6'h00
`define REFPU_RST           3'h0
`define ADAPT_EN_RST        1'b0
`define BANK_FLAG_RST       1'b0
`define SWAP_REQ_RST        1'b0
`define IRQ_RST             4'h0

// analog input power-up codes
`define QCHG_CODE_3P1       6'h31
`define QCHG_CODE_6P4       6'h32
`define QCHG_CODE_1P6       6'h33

// times
`define QCHG_T_1P6_US       1600
`define QCHG_T_3P1_US       3100
`define QCHG_T_6P4_US       6400
`define REF_T_40_MS         40
`define REF_T_80_MS         80
`define REF_T_120_MS        120
`define REF_T_SLOW_MS       250

// interrupt event bits
`define EV_SWAP             0
`define EV_REFUSED          1
`define EV_BAD_QCHG         2
`define EV_RSVD_WR          3
`define EV_COUNT            4

`endif

/* File: src/codec_regs_pkg.sv */
package codec_regs_pkg;

    typedef enum logic [1:0] {
        PWR_IDLE = 2'b00,
        PWR_RAMP = 2'b01,
        PWR_DONE = 2'b10
    } pwr_state_e;

    typedef logic [7:0] reg_byte_t;

endpackage

/* File: tb/codec_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "codec_regs_defs.svh"
module codec_regs_test;
    logic       clock_i   = 1'b0;
    logic       nrst_i    = 1'b0;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [7:0] gain      = 8'h00;
    logic       analog_on = 1'b0;
    logic       adc_on    = 1'b0;
    logic       frame     = 1'b0;
    logic [6:0] faddr     = 7'h00;
    logic [7:0] fdata;
    logic       aen;
    logic       fbank;
    logic       rforce;
    logic       rready;
    logic       iready;
    logic       irq;
    int         errors    = 0;
    int         compares  = 0;

    codec_regs #(.REF_40_CYC(10), .REF_SLOW_CYC(40),
        .IN_1P6_CYC(5), .IN_3P1_CYC(7), .IN_6P4_CYC(9)) uut (
        .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .gain_settled_i(gain), .analog_on_i(analog_on),
        .adc_on_i(adc_on), .adc_frame_i(frame), .filt_addr_i(faddr), .filt_data_o(fdata),
        .adaptive_en_o(aen), .filter_bank_o(fbank), .ref_force_o(rforce),
        .ref_ready_o(rready), .inputs_ready_o(iready), .irq_o(irq));
    host_master host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));

    always #10 clock_i = ~clock_i;

    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] d;
        host.read_reg(a, d);
        chk(d, exp, msg);
    endtask
    task automatic page(input logic [7:0] p);
        host.write_reg(`PAGE_SEL_OFS, p);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return rready;
            1: return iready;
            default: return irq;
        endcase
    endfunction
    // counts edges until the selected output rises, bounded by hi
    task automatic measure(input int sel, input int lo, input int hi, input string msg);
        int n;
        n = 0;
        #1;
        while (pick(sel) !== 1'b1 && n <= hi) begin
            idle(1);
            n++;
        end
        compares++;
        if (n < lo || n > hi) begin
            errors++;
            $display("MISMATCH %0t %s after %0d cycles", $time, msg, n);
            if (n > hi) end_sim();
        end
    endtask

    task automatic t_reset();
        rchk(`PAGE_SEL_OFS, 8'h00, "page reset");
        page(`FLAG_PAGE);
        rchk(`GAIN_FLAGS_OFS, 8'h00, "flags reset");
        rchk(`QCHG_OFS, 8'h00, "input code reset");
        rchk(`REFPU_OFS, 8'h00, "ref code reset");
        page(`COEF_PAGE);
        rchk(`ADAPT_CFG_OFS, 8'h00, "cfg reset");
        chk({6'h00, aen, fbank}, 8'h00, "cfg outs reset");
    endtask
    task automatic t_flags();
        logic [7:0] v [2] = '{8'ha5, 8'h5a};
        page(`FLAG_PAGE);
        foreach (v[i]) begin
            gain <= v[i];
            idle(4);
            rchk(`GAIN_FLAGS_OFS, v[i], "gain flags");
        end
    endtask
    task automatic t_rsvd();
        logic [6:0] a [6] = '{7'h40, 7'h46, 7'h48, 7'h7a, 7'h7c, 7'h7f};
        foreach (a[i]) begin
            host.write_reg(a[i], 8'h00);
            rchk(a[i], 8'h00, "reserved reg");
        end
        host.write_reg(7'h40, 8'hff);
        rchk(7'h40, 8'h00, "reserved nonzero");
        host.write_reg(`QCHG_OFS, 8'hff);
        rchk(`QCHG_OFS, 8'h3f, "input code field");
        host.write_reg(`REFPU_OFS, 8'hff);
        rchk(`REFPU_OFS, 8'h07, "ref code field");
        page(`IRQ_PAGE);
        rchk(`IRQ_STATUS_OFS, 8'h0c, "status events");
        host.write_reg(`IRQ_CLEAR_OFS, 8'h0f);
        rchk(`IRQ_STATUS_OFS, 8'h00, "status cleared");
        rchk(`IRQ_CLEAR_OFS, 8'h00, "clear reads zero");
        page(`FLAG_PAGE);
    endtask
    task automatic t_ref();
        int         n [4] = '{40, 10, 20, 30};
        logic [2:0] c;
        for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            analog_on <= 1'b0;
            host.write_reg(`REFPU_OFS, 8'h00);
            idle(4);
            chk({7'h00, rready}, 8'h00, "ref idle");
            host.write_reg(`REFPU_OFS, {5'h00, c});
            analog_on <= ~c[2];
            measure(0, n[c[1:0]], n[c[1:0]] + 8, "ref time");
            chk({7'h00, rforce}, {7'h00, c[2]}, "ref force");
            rchk(`REFPU_OFS, {5'h00, c}, "ref code");
        end
    endtask
    task automatic t_inputs();
        logic [7:0] c [3] = '{`QCHG_CODE_3P1, `QCHG_CODE_6P4, `QCHG_CODE_1P6};
        int         n [3] = '{7, 9, 5};
        foreach (c[i]) begin
            analog_on <= 1'b0;
            idle(4);
            chk({7'h00, iready}, 8'h00, "inputs idle");
            host.write_reg(`QCHG_OFS, c[i]);
            analog_on <= 1'b1;
            measure(1, n[i], n[i] + 8, "inputs time");
        end
        host.write_reg(`QCHG_OFS, 8'h30);
        idle(4);
        chk({7'h00, iready}, 8'h00, "bad code no ramp");
        analog_on <= 1'b0;
    endtask
    task automatic t_page();
        logic [7:0] p [5] = '{8'hab, `FLAG_PAGE, `COEF_PAGE, `IRQ_PAGE, 8'hff};
        foreach (p[i]) begin
            page(p[i]);
            rchk(`PAGE_SEL_OFS, p[i], "page select");
        end
        rchk(7'h10, 8'h00, "unmapped reads zero");
    endtask
    task automatic t_coef();
        page(`COEF_PAGE);
        host.write_reg(7'h08, 8'h5a);
        host.write_reg(7'h7f, 8'hc3);
        rchk(7'h08, 8'h5a, "coef first");
        rchk(7'h7f, 8'hc3, "coef last");
        rchk(7'h05, 8'h00, "coef page reserved");
        faddr <= 7'd0;
        idle(2);
        chk(fdata, 8'h5a, "filter byte 0");
        faddr <= 7'd119;
        idle(2);
        chk(fdata, 8'hc3, "filter byte 119");
        adc_on <= 1'b1;
        idle(4);
        host.write_reg(7'h08, 8'h11);
        rchk(7'h08, 8'h00, "coef refused");
        chk({7'h00, irq}, 8'h00, "masked event");
        adc_on <= 1'b0;
        idle(4);
        rchk(7'h08, 8'h5a, "coef kept");
    endtask
    task automatic t_swap();
        page(`IRQ_PAGE);
        host.write_reg(`IRQ_CLEAR_OFS, 8'h0f);
        host.write_reg(`IRQ_ENABLE_OFS, 8'h01);
        rchk(`IRQ_ENABLE_OFS, 8'h01, "enable reg");
        page(`COEF_PAGE);
        host.write_reg(`ADAPT_CFG_OFS, 8'h01);
        frame <= 1'b1;
        idle(8);
        frame <= 1'b0;
        rchk(`ADAPT_CFG_OFS, 8'h01, "no swap when off");
        host.write_reg(`ADAPT_CFG_OFS, 8'h04);
        rchk(`ADAPT_CFG_OFS, 8'h04, "adaptive on");
        chk({7'h00, aen}, 8'h01, "adaptive out");
        host.write_reg(7'h08, 8'h77);
        rchk(7'h08, 8'h77, "host bank b");
        faddr <= 7'd0;
        host.write_reg(`ADAPT_CFG_OFS, 8'h05);
        chk(fdata, 8'h5a, "filter bank a");
        chk({7'h00, irq}, 8'h00, "no irq yet");
        frame <= 1'b1;
        measure(2, 3, 8, "swap irq");
        frame <= 1'b0;
        rchk(`ADAPT_CFG_OFS, 8'h06, "swap done");
        chk({7'h00, fbank}, 8'h01, "bank flag out");
        chk(fdata, 8'h77, "filter bank b");
        rchk(7'h08, 8'h5a, "host bank a");
        page(`IRQ_PAGE);
        rchk(`IRQ_STATUS_OFS, 8'h01, "swap status");
        host.write_reg(`IRQ_CLEAR_OFS, 8'h01);
        idle(2);
        chk({7'h00, irq}, 8'h00, "irq cleared");
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        nrst_i <= 1'b1;
        t_reset();
        t_flags();
        t_rsvd();
        t_ref();
        t_inputs();
        t_page();
        t_coef();
        t_swap();
        end_sim();
    end
endmodule // codec_regs_test
`default_nettype wire

/* File: tb/host_master.sv */
`timescale 1ns/100ps
`default_nettype none
module host_master (
    input  wire logic       clock_i,
    input  wire logic [7:0] rdata_i,
    output logic      [6:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial begin
        addr_o  = 7'h00;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end
    // one-cycle write strobe beside address and data
    task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_o    <= 1'b1;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge clock_i);
        wr_o    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
        @(posedge clock_i);
        rd_o   <= 1'b1;
        addr_o <= a;
        @(posedge clock_i);
        rd_o   <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule // host_master
`default_nettype wire
